//--- cpl_frame_mem.sv
// Small frame memory: one write port, one read port, registered read.
// Assumes: written and read on core_clk only.
`timescale 1ns/10ps
module cpl_frame_mem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Write port
  input wire logic we,
  input wire logic [cpl_pkg::MEM_AW-1:0] waddr,
  input wire logic [31:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [cpl_pkg::MEM_AW-1:0] raddr,
  output logic [31:0] rdata_q
);

  logic [31:0] mem [cpl_pkg::MEM_DEPTH];

  // No reset on the array, it maps onto plain RAM
  always_ff @(posedge core_clk) begin
    if (clk_en && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= cpl_pkg::REG_RESET;
    end else if (clk_en && re) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule // cpl_frame_mem

//--- cpl_loader.sv
// Configuration packet decoder, CRC checker, frame loader and readback.
// Assumes: config_clock, word strobe, capture pins and user state are
// asynchronous; core_clk runs far faster than config_clock.
`timescale 1ns/10ps
module cpl_loader (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Configuration link pins
  input wire logic config_clock,
  input wire logic cfg_word_valid,
  input wire logic [31:0] cfg_word,
  // Capture pins
  input wire logic capture_clock,
  input wire logic capture_enable,
  input wire logic [31:0] user_state,
  // Readback
  output logic [31:0] rb_word,
  output logic rb_valid_q,
  // Status
  output logic synced_q,
  output logic crc_error_q,
  output logic [15:0] crc_q,
  output logic last_frame_q,
  output logic done_q,
  output logic user_active_q,
  // Register views
  output logic [31:0] control_q,
  output logic [31:0] config_options_q,
  output logic [31:0] frame_length_q
);

  // ***************************************************************
  // Input synchronisers and edge detection
  // ***************************************************************
  logic [cpl_pkg::SYNC_W-1:0] async_in;
  logic [cpl_pkg::SYNC_W-1:0] sync1_q;
  logic [cpl_pkg::SYNC_W-1:0] sync2_q;
  logic config_clock_prev_q;
  logic capclk_prev_q;
  logic [31:0] word_s;
  logic [31:0] user_s;
  logic valid_s;
  logic config_clock_s;
  logic capen_s;
  logic capclk_s;
  logic config_clock_rise;
  logic cap_rise;
  logic word_take;

  assign async_in = {cfg_word_valid, config_clock, capture_enable,
                     capture_clock, user_state, cfg_word};
  assign word_s = sync2_q[31:0];
  assign user_s = sync2_q[63:32];
  assign capclk_s = sync2_q[64];
  assign capen_s = sync2_q[65];
  assign config_clock_s = sync2_q[66];
  assign valid_s = sync2_q[67];

  // Data settles long before the slow link edge, so bulk sync is safe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      config_clock_prev_q <= 1'b0;
      capclk_prev_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      config_clock_prev_q <= config_clock_s;
      capclk_prev_q <= capclk_s;
    end
  end

  assign config_clock_rise = config_clock_s & ~config_clock_prev_q;
  assign cap_rise = capclk_s & ~capclk_prev_q;
  assign word_take = config_clock_rise & valid_s;

  // ***************************************************************
  // CRC step
  // ***************************************************************
  // shift register taps
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [35:0] bits);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 36; i++) begin
      fb = bits[i] ^ r[15];
      r = {r[14:0], fb};
      r[2] = r[2] ^ fb;
      r[15] = r[15] ^ fb;
    end
    return r;
  endfunction

  // ***************************************************************
  // Packet decoder
  // ***************************************************************
  cpl_pkg::cpl_state_t state_q;
  logic [cpl_pkg::ADDR_W-1:0] addr_q;
  logic [cpl_pkg::CNT_W-1:0] count_q;
  logic t2_ok_q;
  logic write_config_cmd_q;
  logic rcfg_q;
  logic [2:0] hdr_type;
  logic [1:0] hdr_op;
  logic [cpl_pkg::ADDR_W-1:0] t1_addr;
  logic [cpl_pkg::CNT_W-1:0] t1_cnt;
  logic [cpl_pkg::CNT_W-1:0] t2_cnt;
  logic rd_ok;

  assign hdr_type = word_s[cpl_pkg::TYPE_HI:cpl_pkg::TYPE_LO];
  assign hdr_op = word_s[cpl_pkg::OP_HI:cpl_pkg::OP_LO];
  assign t1_addr = word_s[cpl_pkg::T1_ADDR_HI:cpl_pkg::T1_ADDR_LO];
  assign t1_cnt = {16'h0000, word_s[cpl_pkg::T1_CNT_HI:0]};
  assign t2_cnt = word_s[cpl_pkg::T2_CNT_HI:0];
  assign rd_ok = rcfg_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= cpl_pkg::ST_UNSYNC;
      addr_q <= '0;
      count_q <= '0;
      t2_ok_q <= 1'b0;
    end else if (clk_en && config_clock_rise) begin
      case (state_q)
        cpl_pkg::ST_UNSYNC: begin
          if (valid_s && word_s == cpl_pkg::SYNC_WORD) begin
            state_q <= cpl_pkg::ST_HDR;
          end
        end
        cpl_pkg::ST_HDR: begin
          if (valid_s) begin
            t2_ok_q <= 1'b0;
            if (hdr_type == cpl_pkg::HDR_TYPE1) begin
              addr_q <= t1_addr;
              count_q <= t1_cnt;
              // Type 1 alone or opening a pair
              if (t1_cnt == '0) begin
                t2_ok_q <= 1'b1;
              end else if (hdr_op == cpl_pkg::OP_WRITE) begin
                state_q <= cpl_pkg::ST_WDATA;
              end else if (hdr_op == cpl_pkg::OP_READ && rd_ok &&
                           t1_addr == cpl_pkg::REG_FRAME_DATA_OUT) begin
                state_q <= cpl_pkg::ST_RDATA;
              end
            // Type 2 only after empty Type 1
            end else if (hdr_type == cpl_pkg::HDR_TYPE2 && t2_ok_q &&
                         t2_cnt != '0) begin
              count_q <= t2_cnt;
              if (hdr_op == cpl_pkg::OP_WRITE) begin
                state_q <= cpl_pkg::ST_WDATA;
              end else if (hdr_op == cpl_pkg::OP_READ && rd_ok &&
                           addr_q == cpl_pkg::REG_FRAME_DATA_OUT) begin
                state_q <= cpl_pkg::ST_RDATA;
              end
            end
          end
        end
        cpl_pkg::ST_WDATA: begin
          if (valid_s) begin
            count_q <= count_q - 1'b1;
            if (count_q == 27'h000_0001) begin
              state_q <= cpl_pkg::ST_HDR;
            end
          end
        end
        // one word out per link edge
        cpl_pkg::ST_RDATA: begin
          count_q <= count_q - 1'b1;
          if (count_q == 27'h000_0001) begin
            state_q <= cpl_pkg::ST_HDR;
          end
        end
        default: state_q <= cpl_pkg::ST_UNSYNC;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      synced_q <= 1'b0;
    end else if (clk_en) begin
      synced_q <= (state_q != cpl_pkg::ST_UNSYNC);
    end
  end

  // ***************************************************************
  // Register writes and commands
  // ***************************************************************
  logic wr_en;
  logic cmd_wr;
  logic [31:0] mask_q;
  logic [cpl_pkg::MEM_AW-1:0] frame_ptr_q;
  logic frame_wr;
  logic rd_step;

  assign wr_en = clk_en & word_take & (state_q == cpl_pkg::ST_WDATA);
  assign cmd_wr = wr_en & (addr_q == cpl_pkg::REG_COMMAND);
  // frame words land only while writing is armed
  assign frame_wr = wr_en & write_config_cmd_q &
                    (addr_q == cpl_pkg::REG_FRAME_DATA_IN);
  assign rd_step = clk_en & config_clock_rise & (state_q == cpl_pkg::ST_RDATA);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_q <= cpl_pkg::REG_RESET;
      mask_q <= cpl_pkg::REG_RESET;
      config_options_q <= cpl_pkg::REG_RESET;
      frame_length_q <= cpl_pkg::REG_RESET;
    end else if (wr_en) begin
      case (addr_q)
        // Only bits opened by the mask may change
        cpl_pkg::REG_CONTROL:
          control_q <= (control_q & ~mask_q) | (word_s & mask_q);
        cpl_pkg::REG_CONTROL_MASK: mask_q <= word_s;
        cpl_pkg::REG_CONFIG_OPTIONS: config_options_q <= word_s;
        cpl_pkg::REG_FRAME_LENGTH: frame_length_q <= word_s;
        default: control_q <= control_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      write_config_cmd_q <= 1'b0;
      rcfg_q <= 1'b0;
      last_frame_q <= 1'b0;
    end else if (cmd_wr) begin
      if (word_s == cpl_pkg::CMD_WRITE_CONFIG) begin
        write_config_cmd_q <= 1'b1;
        rcfg_q <= 1'b0;
      end else if (word_s == cpl_pkg::CMD_READ_CONFIG) begin
        rcfg_q <= 1'b1;
        write_config_cmd_q <= 1'b0;
      end else if (word_s == cpl_pkg::CMD_LAST_FRAME) begin
        last_frame_q <= 1'b1;
      end
    end
  end

  // pointer runs on without a new frame address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_ptr_q <= '0;
    end else if (wr_en && addr_q == cpl_pkg::REG_FRAME_ADDRESS) begin
      frame_ptr_q <= word_s[cpl_pkg::MEM_AW-1:0];
    end else if (frame_wr || rd_step) begin
      frame_ptr_q <= frame_ptr_q + 1'b1;
    end
  end

  // ***************************************************************
  // CRC accumulator and check
  // ***************************************************************
  logic covered;
  logic [15:0] crc_next;
  logic crc_wr;

  assign covered = (addr_q == cpl_pkg::REG_CRC_CHECK) ||
                   (addr_q == cpl_pkg::REG_FRAME_ADDRESS) ||
                   (addr_q == cpl_pkg::REG_FRAME_DATA_IN) ||
                   (addr_q == cpl_pkg::REG_COMMAND) ||
                   (addr_q == cpl_pkg::REG_CONTROL) ||
                   (addr_q == cpl_pkg::REG_CONTROL_MASK) ||
                   (addr_q == cpl_pkg::REG_CONFIG_OPTIONS) ||
                   (addr_q == cpl_pkg::REG_FRAME_LENGTH);
  assign crc_next = crc_step(crc_q, {addr_q[3:0], word_s});
  assign crc_wr = wr_en & (addr_q == cpl_pkg::REG_CRC_CHECK);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_q <= cpl_pkg::CRC_RESET;
    end else if (cmd_wr && word_s == cpl_pkg::CMD_CRC_RESET) begin
      crc_q <= cpl_pkg::CRC_RESET;
    end else if (wr_en && covered) begin
      crc_q <= crc_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_error_q <= 1'b0;
    end else if (crc_wr && crc_next != cpl_pkg::CRC_RESET) begin
      crc_error_q <= 1'b1;
    end
  end

  // ***************************************************************
  // Start-up sequence
  // ***************************************************************
  logic start_armed_q;
  logic run_q;
  logic [4:0] edge_cnt_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_armed_q <= 1'b0;
      run_q <= 1'b0;
      edge_cnt_q <= '0;
      done_q <= 1'b0;
      user_active_q <= 1'b0;
    end else if (clk_en) begin
      if (cmd_wr && word_s == cpl_pkg::CMD_START) begin
        start_armed_q <= 1'b1;
      end
      // wait for the final CRC word
      if (crc_wr && start_armed_q && !crc_error_q &&
          crc_next == cpl_pkg::CRC_RESET) begin
        run_q <= 1'b1;
        start_armed_q <= 1'b0;
        edge_cnt_q <= '0;
      end else if (run_q && config_clock_rise) begin
        edge_cnt_q <= edge_cnt_q + 1'b1;
        if (edge_cnt_q == cpl_pkg::DONE_EDGES - 5'h01) begin
          done_q <= 1'b1;
        end
        if (edge_cnt_q == cpl_pkg::ACTIVE_EDGES - 5'h01) begin
          user_active_q <= 1'b1;
          run_q <= 1'b0;
        end
      end
    end
  end

  // ***************************************************************
  // Capture and frame memory
  // ***************************************************************
  logic cap_pend_q;
  logic cap_wr;
  logic [31:0] cap_data_q;
  logic mem_we;
  logic [cpl_pkg::MEM_AW-1:0] mem_waddr;
  logic [31:0] mem_wdata;

  // Frame writes own the port; a capture waits one cycle if needed
  assign cap_wr = cap_pend_q & ~frame_wr;
  assign mem_we = frame_wr | cap_wr;
  assign mem_waddr = frame_wr ? frame_ptr_q : cpl_pkg::CAPTURE_ADDR;
  assign mem_wdata = frame_wr ? word_s : cap_data_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_pend_q <= 1'b0;
      cap_data_q <= cpl_pkg::REG_RESET;
    end else if (clk_en) begin
      if (cap_rise && capen_s) begin
        cap_pend_q <= 1'b1;
        cap_data_q <= user_s;
      end else if (cap_wr) begin
        cap_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_valid_q <= 1'b0;
    end else if (clk_en) begin
      rb_valid_q <= rd_step;
    end
  end

  cpl_frame_mem u_mem (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .re(rd_step),
    .raddr(frame_ptr_q),
    .rdata_q(rb_word)
  );

endmodule // cpl_loader

//--- cpl_loader_asserts.sv
// Checker for the loader status ports.
// Assumes: bound into cpl_loader; one clock domain.
`timescale 1ns/10ps
module cpl_loader_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Status
  input wire logic rb_valid_q,
  input wire logic synced_q,
  input wire logic crc_error_q,
  input wire logic [15:0] crc_q,
  input wire logic done_q,
  input wire logic user_active_q,
  input wire logic [31:0] control_q,
  input wire logic [31:0] frame_length_q
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Done and active are many link clocks apart
  sequence idle_s;
    !user_active_q [*8];
  endsequence
  sequence hold_s;
    ##1 idle_s;
  endsequence
  a_unsync_quiet: assert property (!synced_q |->
    crc_q == 16'h0000 && control_q == 32'h0000_0000 &&
    frame_length_q == 32'h0000_0000) else $error("change before sync");
  a_err_sticky: assert property (crc_error_q |=> crc_error_q)
    else $error("crc error flag dropped");
  a_err_cause: assert property ($rose(crc_error_q) |->
    ##[0:1] crc_q != 16'h0000) else $error("error with zero remainder");
  a_done_zero: assert property (done_q |-> crc_q == 16'h0000)
    else $error("remainder not zero while done");
  a_done_wait: assert property ($rose(done_q) |-> hold_s)
    else $error("active too soon after done");
  a_active_done: assert property (user_active_q |-> done_q)
    else $error("active without done");
  a_active_clean: assert property (user_active_q |-> !crc_error_q)
    else $error("active despite crc error");
  a_active_late: assert property ($rose(user_active_q) |->
    $past(done_q, 8)) else $error("done not ahead of active");
  a_rb_pulse: assert property (rb_valid_q |=> !rb_valid_q)
    else $error("readback strobe too long");
endmodule // cpl_loader_chk

bind cpl_loader cpl_loader_chk u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .rb_valid_q(rb_valid_q), .synced_q(synced_q), .crc_error_q(crc_error_q),
  .crc_q(crc_q), .done_q(done_q), .user_active_q(user_active_q),
  .control_q(control_q), .frame_length_q(frame_length_q));

//--- cpl_pkg.sv
// Constants and types for the configuration packet loader.
// Assumes: single core clock domain; no other package needed.
package cpl_pkg;

  // ***************************************************************
  // Packet header fields
  // ***************************************************************
  localparam int TYPE_HI = 31;
  localparam int TYPE_LO = 29;
  localparam int OP_HI = 28;
  localparam int OP_LO = 27;
  localparam int T1_ADDR_HI = 26;
  localparam int T1_ADDR_LO = 13;
  localparam int T1_CNT_HI = 10;
  localparam int T2_CNT_HI = 26;
  localparam int ADDR_W = 14;
  localparam int CNT_W = 27;
  localparam logic [2:0] HDR_TYPE1 = 3'h1;
  localparam logic [2:0] HDR_TYPE2 = 3'h2;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [31:0] SYNC_WORD = 32'haa99_5566;

  // ***************************************************************
  // Register address codes
  // ***************************************************************
  localparam logic [ADDR_W-1:0] REG_CRC_CHECK = 14'h0000;
  localparam logic [ADDR_W-1:0] REG_FRAME_ADDRESS = 14'h0001;
  localparam logic [ADDR_W-1:0] REG_FRAME_DATA_IN = 14'h0002;
  localparam logic [ADDR_W-1:0] REG_FRAME_DATA_OUT = 14'h0003;
  localparam logic [ADDR_W-1:0] REG_COMMAND = 14'h0004;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 14'h0005;
  localparam logic [ADDR_W-1:0] REG_CONTROL_MASK = 14'h0006;
  localparam logic [ADDR_W-1:0] REG_CONFIG_OPTIONS = 14'h0009;
  localparam logic [ADDR_W-1:0] REG_FRAME_LENGTH = 14'h000b;

  // ***************************************************************
  // Command codes
  // ***************************************************************
  localparam logic [31:0] CMD_WRITE_CONFIG = 32'h0000_0001;
  localparam logic [31:0] CMD_LAST_FRAME = 32'h0000_0003;
  localparam logic [31:0] CMD_READ_CONFIG = 32'h0000_0004;
  localparam logic [31:0] CMD_START = 32'h0000_0005;
  localparam logic [31:0] CMD_CRC_RESET = 32'h0000_0007;

  // ***************************************************************
  // Reset values, memory and start-up timing
  // ***************************************************************
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;
  localparam logic [MEM_AW-1:0] CAPTURE_ADDR = 6'h3f;
  localparam int SYNC_W = 68;
  // Config clock edges after the final CRC word
  localparam logic [4:0] DONE_EDGES = 5'h07;
  localparam logic [4:0] ACTIVE_EDGES = 5'h10;

  typedef enum logic [1:0] {
    ST_UNSYNC = 2'b00,
    ST_HDR = 2'b01,
    ST_WDATA = 2'b10,
    ST_RDATA = 2'b11
  } cpl_state_t;

endpackage

//--- cpl_source.sv
// Model of the configuration source driving stream words.
// Assumes: core_clk from the bench; one word per 80 ns link clock.
`timescale 1ns/10ps
module cpl_source (
  // Clock
  input wire logic core_clk,
  // Link pins
  output logic config_clock,
  output logic cfg_word_valid,
  output logic [31:0] cfg_word
);
  // ****************
  // Word transfer
  // ****************
  initial begin
    config_clock = 1'b0;
    cfg_word_valid = 1'b0;
    cfg_word = 32'h0000_0000;
  end
  // Clock stands still between words; stale data is inverted
  task automatic send(input logic [31:0] w, input logic v);
    @(posedge core_clk);
    cfg_word <= w;
    cfg_word_valid <= v;
    repeat (2) @(posedge core_clk);
    config_clock <= 1'b1;
    repeat (4) @(posedge core_clk);
    config_clock <= 1'b0;
    @(posedge core_clk);
    cfg_word <= ~w;
    cfg_word_valid <= 1'b0;
  endtask
endmodule // cpl_source

//--- tb.sv
// Self-checking bench for the configuration packet loader.
// Assumes: cpl_pkg compiled first; cpl_source drives the link.
`timescale 1ns/10ps
module tb;
  // ****************
  // Signals and instances
  // ****************
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic capture_clock = 1'b0;
  logic capture_enable = 1'b0;
  logic [31:0] user_state = 32'h0000_0000;
  logic config_clock, cfg_word_valid, rb_valid_q, synced_q, crc_error_q;
  logic last_frame_q, done_q, user_active_q;
  logic [31:0] cfg_word, rb_word, control_q, config_options_q;
  logic [31:0] frame_length_q;
  logic [15:0] crc_q;
  logic [15:0] crc_m = 16'h0000;
  logic [31:0] rb_q[$];
  logic [31:0] exp_rb[4] = '{32'h5a5a_a5a5, 32'hcafe_0001, 32'hcafe_0002,
    32'hbeef_0003};
  int miscompares = 0;
  int cmp_count = 0;
  always #5 core_clk = ~core_clk;
  cpl_source u_src (.core_clk(core_clk), .config_clock(config_clock),
    .cfg_word_valid(cfg_word_valid), .cfg_word(cfg_word));
  cpl_loader DUT (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1),
    .config_clock(config_clock), .cfg_word_valid(cfg_word_valid),
    .cfg_word(cfg_word), .capture_clock(capture_clock),
    .capture_enable(capture_enable), .user_state(user_state),
    .rb_word(rb_word), .rb_valid_q(rb_valid_q), .synced_q(synced_q),
    .crc_error_q(crc_error_q), .crc_q(crc_q), .last_frame_q(last_frame_q),
    .done_q(done_q), .user_active_q(user_active_q), .control_q(control_q),
    .config_options_q(config_options_q), .frame_length_q(frame_length_q));
  always @(posedge core_clk) begin
    if (rb_valid_q === 1'b1) begin
      rb_q.push_back(rb_word);
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c,
      input logic [35:0] b);
    logic [15:0] n;
    logic fb;
    for (int i = 0; i < 36; i++) begin
      fb = b[i] ^ c[15];
      n = {c[14:0], fb};
      n[2] = c[1] ^ fb;
      n[15] = c[14] ^ fb;
      c = n;
    end
    return c;
  endfunction
  // Search is slow but only runs a few times
  function automatic logic [31:0] crc_fix(input logic [15:0] c);
    for (int v = 0; v < 65536; v++) begin
      if (crc_step(c, {20'h0_0000, 16'(v)}) == 16'h0000) begin
        return {16'h0000, 16'(v)};
      end
    end
    return 32'h0000_0000;
  endfunction
  task automatic put(input logic [13:0] a, input logic [31:0] d);
    u_src.send(d, 1'b1);
    crc_m = crc_step(crc_m, {a[3:0], d});
    if (a == cpl_pkg::REG_COMMAND && d == cpl_pkg::CMD_CRC_RESET) begin
      crc_m = 16'h0000;
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    u_src.send({3'h1, 2'h2, a, 2'b00, 11'h001}, 1'b1);
    put(a, d);
  endtask
  task automatic dummies(input int n);
    repeat (n) u_src.send(32'h0000_0000, 1'b1);
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    arst_n <= 1'b0;
    crc_m = 16'h0000;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic cap(input logic en, input logic [31:0] v);
    @(posedge core_clk);
    capture_enable <= en;
    user_state <= v;
    repeat (3) @(posedge core_clk);
    capture_clock <= 1'b1;
    repeat (4) @(posedge core_clk);
    capture_clock <= 1'b0;
    capture_enable <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (50000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    do_reset();
    // Bad check word, then a good one: start-up must stay off
    u_src.send(cpl_pkg::SYNC_WORD, 1'b1);
    wr(cpl_pkg::REG_FRAME_LENGTH, 32'h0000_0014);
    wr(cpl_pkg::REG_CRC_CHECK, crc_fix(crc_m) ^ 32'h0000_0001);
    chk(32'(crc_error_q), 32'h0000_0001);
    wr(cpl_pkg::REG_COMMAND, cpl_pkg::CMD_START);
    wr(cpl_pkg::REG_CRC_CHECK, crc_fix(crc_m));
    dummies(18);
    chk(32'({crc_error_q, done_q, user_active_q}), 32'h0000_0004);
    do_reset();
    wr(cpl_pkg::REG_FRAME_LENGTH, 32'h0000_0014);
    chk(frame_length_q, 32'h0000_0000);
    crc_m = 16'h0000;
    u_src.send(cpl_pkg::SYNC_WORD, 1'b1);
    chk(32'(synced_q), 32'h0000_0001);
    // Accumulator must be nonzero before the reset command is tried
    wr(cpl_pkg::REG_FRAME_LENGTH, 32'h0000_0014);
    chk(frame_length_q, 32'h0000_0014);
    wr(cpl_pkg::REG_COMMAND, cpl_pkg::CMD_CRC_RESET);
    chk(32'(crc_q), 32'h0000_0000);
    wr(cpl_pkg::REG_CONFIG_OPTIONS, 32'h8421_0f0f);
    chk(config_options_q, 32'h8421_0f0f);
    // Stray Type 2 header with no empty Type 1 ahead must be refused
    u_src.send(32'h5000_0001, 1'b1);
    u_src.send(32'h0000_0000, 1'b1);
    chk(config_options_q, 32'h8421_0f0f);
    chk(32'(crc_q), 32'(crc_m));
    wr(cpl_pkg::REG_FRAME_ADDRESS, 32'h0000_0000);
    wr(cpl_pkg::REG_COMMAND, cpl_pkg::CMD_WRITE_CONFIG);
    u_src.send(32'h3000_4000, 1'b1);
    u_src.send(32'h5000_0002, 1'b1);
    put(cpl_pkg::REG_FRAME_DATA_IN, 32'hcafe_0001);
    put(cpl_pkg::REG_FRAME_DATA_IN, 32'hcafe_0002);
    chk(32'(crc_q), 32'(crc_m));
    wr(cpl_pkg::REG_FRAME_ADDRESS, 32'h0000_0002);
    wr(cpl_pkg::REG_FRAME_DATA_IN, 32'hbeef_0003);
    cap(1'b1, 32'h5a5a_a5a5);
    cap(1'b0, 32'ha5a5_5a5a);
    wr(cpl_pkg::REG_FRAME_ADDRESS, 32'h0000_003f);
    wr(cpl_pkg::REG_COMMAND, cpl_pkg::CMD_READ_CONFIG);
    u_src.send(32'h2800_6000, 1'b1);
    u_src.send(32'h4800_0004, 1'b1);
    rb_q.delete();
    repeat (4) u_src.send(32'h0000_0000, 1'b0);
    for (int i = 0; i < 20 && rb_q.size() < 4; i++) @(posedge core_clk);
    chk(32'(rb_q.size()), 32'h0000_0004);
    foreach (exp_rb[i]) chk(rb_q[i], exp_rb[i]);
    wr(cpl_pkg::REG_CRC_CHECK, crc_fix(crc_m));
    chk(32'({crc_error_q, crc_q}), 32'h0000_0000);
    wr(cpl_pkg::REG_COMMAND, cpl_pkg::CMD_LAST_FRAME);
    chk(32'(last_frame_q), 32'h0000_0001);
    wr(cpl_pkg::REG_FRAME_DATA_IN, 32'h0f0f_0004);
    wr(cpl_pkg::REG_COMMAND, cpl_pkg::CMD_START);
    wr(cpl_pkg::REG_CONTROL_MASK, 32'hffff_ffff);
    wr(cpl_pkg::REG_CONTROL, 32'h0000_00a5);
    chk(control_q, 32'h0000_00a5);
    chk(32'(user_active_q), 32'h0000_0000);
    wr(cpl_pkg::REG_CRC_CHECK, crc_fix(crc_m));
    for (int i = 1; i <= 17; i++) begin
      u_src.send(32'h0000_0000, 1'b1);
      if (i == 5 || i == 8) chk(32'(done_q), 32'(i == 8));
      if (i == 14 || i == 17) chk(32'(user_active_q), 32'(i == 17));
    end
    print_verdict();
  end
endmodule // tb
